// ---- logic/iepr_cfg.svh ----
// register offsets, field positions, reset values and timing counts
// assumes an 8-bit special-function register space with 8051-style bit addressing
`ifndef IEPR_CFG_SVH
`define IEPR_CFG_SVH

// byte addresses, identical on every register page
`define IEPR_ADDR_ENMAIN  8'ha8
`define IEPR_ADDR_PRIMAIN 8'hb8
`define IEPR_ADDR_ENEXT1  8'he6

// field positions
`define IEPR_GATE_BIT     7
`define IEPR_SPI_BIT      6
`define IEPR_PRI_FREE_BIT 7

// reset values
`define IEPR_RST_ENMAIN   8'h00
`define IEPR_RST_PRIMAIN  7'h00
`define IEPR_RST_ENEXT1   8'h00

// timing in system clock cycles at 50 MHz
`define IEPR_CLK_MHZ      50
`define IEPR_DETECT_CYC   1
`define IEPR_CALL_CYC     4
`define IEPR_RESP_CYC     (`IEPR_DETECT_CYC + `IEPR_CALL_CYC)

`endif

// ---- logic/iepr_pkg.sv ----
// types shared by the interrupt enable and priority block
// assumes the constants of iepr_cfg.svh
package iepr_pkg;

  typedef enum logic [0:0] {
    PH_IDLE,
    PH_CALL
  } iepr_phase_t;

  typedef struct packed {
    logic [7:0]  enMain;
    logic [6:0]  priMain;
    logic [7:0]  enExt1;
    logic [7:0]  rdData;
    logic        bitData;
    iepr_phase_t phase;
    logic [2:0]  callCnt;
    logic [3:0]  vec;
    logic        vecHigh;
    logic        actHigh;
    logic        actLow;
  } iepr_state_t;

endpackage

// ---- logic/iepr_regs.sv ----
// interrupt enable and priority registers with request gating and arbitration
// assumes synchronous special-function register strobes from the core and
// peripheral pending flags that are levels held until software clears them
`timescale 1ns/1ps
`include "iepr_cfg.svh"

module iepr_regs
  import iepr_pkg::*;
#(
  parameter int NSRC = 15
) (
  input  wire logic       clk,
  input  wire logic       rst_b,
  // byte access to the register space
  input  wire logic [7:0] sfrAddr,
  input  wire logic       sfrWr,
  input  wire logic       sfrRd,
  input  wire logic [7:0] sfrWdata,
  output logic      [7:0] sfrRdata,
  // single-bit access
  input  wire logic [7:0] bitAddr,
  input  wire logic       bitWr,
  input  wire logic       bitRd,
  input  wire logic       bitWval,
  output logic            bitRdata,
  // peripheral pending flags
  input  wire logic       extPinZero,
  input  wire logic       timerZeroOverflow,
  input  wire logic       extPinOne,
  input  wire logic       timerOneOverflow,
  input  wire logic       asyncSerialPort,
  input  wire logic       timerTwoLowOverflow,
  input  wire logic       timerTwoHighOverflow,
  input  wire logic       serialPeriphPort,
  input  wire logic       smbusPort,
  input  wire logic       windowCompareFlag,
  input  wire logic       conversionDoneFlag,
  input  wire logic       counterArray,
  input  wire logic       comparatorZeroRise,
  input  wire logic       comparatorZeroFall,
  input  wire logic       comparatorOneRise,
  input  wire logic       comparatorOneFall,
  input  wire logic       timerThreeLowOverflow,
  input  wire logic       timerThreeHighOverflow,
  input  wire logic       linCtrlEvent,
  // levels of the extended sources, from the extended priority register
  input  wire logic [7:0] extLevel,
  // core sequencer side
  input  wire logic       svcReturn,
  output logic            irqBusy,
  output logic            irqEnter,
  output logic      [3:0] irqVector,
  output logic            irqHigh,
  output logic      [7:0] enMainOut,
  output logic      [7:0] enExt1Out
);

  iepr_state_t st;
  iepr_state_t next_st;

  logic [NSRC-1:0] srcPend;
  logic [NSRC-1:0] srcMask;
  logic [NSRC-1:0] srcLevel;
  logic [NSRC-1:0] srcReq;
  logic [NSRC-1:0] srcElig;
  logic [NSRC-1:0] hiElig;
  logic            gateOn;
  logic            anyElig;
  logic            anyHigh;
  logic [3:0]      winIdx;
  logic [7:0]      priRead;

  // pending flags in fixed service order; flags only read, never altered
  assign srcPend = {linCtrlEvent,
                    timerThreeLowOverflow | timerThreeHighOverflow,
                    comparatorOneRise | comparatorOneFall,
                    comparatorZeroRise | comparatorZeroFall,
                    counterArray,
                    conversionDoneFlag,
                    windowCompareFlag,
                    smbusPort,
                    serialPeriphPort,
                    timerTwoLowOverflow | timerTwoHighOverflow,
                    asyncSerialPort,
                    timerOneOverflow,
                    extPinOne,
                    timerZeroOverflow,
                    extPinZero};

  // mask and level bits line up with the service order
  assign srcMask  = {st.enExt1, st.enMain[6:0]};
  assign srcLevel = {extLevel, st.priMain};
  assign gateOn   = st.enMain[`IEPR_GATE_BIT];

  // per-source gating, re-evaluated every clock
  genvar gi;
  generate
    for (gi = 0; gi < NSRC; gi++) begin : g_src
      assign srcReq[gi]  = gateOn & srcMask[gi] & srcPend[gi];
      assign srcElig[gi] = srcReq[gi] & ~st.actHigh &
                           (~st.actLow | srcLevel[gi]);
      assign hiElig[gi]  = srcElig[gi] & srcLevel[gi];
    end
  endgenerate

  // lowest index wins among the set bits
  function automatic logic [3:0] pick_first(input logic [NSRC-1:0] v);
    logic [3:0] idx;
    idx = 4'h0;
    for (int i = NSRC - 1; i >= 0; i--) begin
      if (v[i]) begin
        idx = 4'(i);
      end
    end
    return idx;
  endfunction

  // high level first, then fixed order within a level
  assign anyElig = |srcElig;
  assign anyHigh = |hiElig;
  assign winIdx  = anyHigh ? pick_first(hiElig) : pick_first(srcElig);

  // unused priority bit always reads one
  assign priRead = {1'b1, st.priMain};

  // next-state logic: registers, read data and call sequencing
  always_comb begin
    logic [2:0] bsel;
    bsel    = bitAddr[2:0];
    next_st = st;
    // byte writes, address decode ignores the register page
    if (sfrWr) begin
      case (sfrAddr)
        `IEPR_ADDR_ENMAIN: begin
          next_st.enMain = sfrWdata;
        end
        `IEPR_ADDR_PRIMAIN: begin
          next_st.priMain = sfrWdata[6:0];
        end
        `IEPR_ADDR_ENEXT1: begin
          next_st.enExt1 = sfrWdata;
        end
        default: begin
        end
      endcase
    end
    // bit writes; the extended enable is byte access only
    if (bitWr) begin
      if (bitAddr[7:3] == 5'(`IEPR_ADDR_ENMAIN >> 3)) begin
        next_st.enMain[bsel] = bitWval;
      end else if (bitAddr[7:3] == 5'(`IEPR_ADDR_PRIMAIN >> 3)) begin
        if (bsel != 3'(`IEPR_PRI_FREE_BIT)) begin
          next_st.priMain[bsel] = bitWval;
        end
      end
    end
    // byte reads, unmapped addresses return zero
    if (sfrRd) begin
      case (sfrAddr)
        `IEPR_ADDR_ENMAIN:  next_st.rdData = st.enMain;
        `IEPR_ADDR_PRIMAIN: next_st.rdData = priRead;
        `IEPR_ADDR_ENEXT1:  next_st.rdData = st.enExt1;
        default:            next_st.rdData = 8'h00;
      endcase
    end
    // bit reads
    if (bitRd) begin
      if (bitAddr[7:3] == 5'(`IEPR_ADDR_ENMAIN >> 3)) begin
        next_st.bitData = st.enMain[bsel];
      end else if (bitAddr[7:3] == 5'(`IEPR_ADDR_PRIMAIN >> 3)) begin
        next_st.bitData = priRead[bsel];
      end else begin
        next_st.bitData = 1'b0;
      end
    end
    // routine return frees the innermost active level
    if (svcReturn) begin
      if (st.actHigh) begin
        next_st.actHigh = 1'b0;
      end else begin
        next_st.actLow = 1'b0;
      end
    end
    // one detect cycle then the call sequence
    case (st.phase)
      PH_IDLE: begin
        if (anyElig) begin
          next_st.phase   = PH_CALL;
          next_st.vec     = winIdx;
          next_st.vecHigh = anyHigh;
          next_st.callCnt = 3'(`IEPR_CALL_CYC - 1);
        end
      end
      PH_CALL: begin
        if (st.callCnt == 3'h0) begin
          next_st.phase = PH_IDLE;
          if (st.vecHigh) begin
            next_st.actHigh = 1'b1;
          end else begin
            next_st.actLow = 1'b1;
          end
        end else begin
          next_st.callCnt = st.callCnt - 3'h1;
        end
      end
      default: begin
        next_st.phase = PH_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st.enMain  <= `IEPR_RST_ENMAIN;
      st.priMain <= `IEPR_RST_PRIMAIN;
      st.enExt1  <= `IEPR_RST_ENEXT1;
      st.rdData  <= 8'h00;
      st.bitData <= 1'b0;
      st.phase   <= PH_IDLE;
      st.callCnt <= 3'h0;
      st.vec     <= 4'h0;
      st.vecHigh <= 1'b0;
      st.actHigh <= 1'b0;
      st.actLow  <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  // outputs
  assign sfrRdata  = st.rdData;
  assign bitRdata  = st.bitData;
  assign irqBusy   = (st.phase == PH_CALL);
  assign irqEnter  = (st.phase == PH_CALL) && (st.callCnt == 3'h0);
  assign irqVector = st.vec;
  assign irqHigh   = st.vecHigh;
  assign enMainOut = st.enMain;
  assign enExt1Out = st.enExt1;

  // checks on gating, registers and sequencing
  chk_gate_blocks: assert property (@(posedge clk) disable iff (!rst_b)
    !gateOn |-> !anyElig)
    else $error("request passed with global gate off");

  chk_enmain_write: assert property (@(posedge clk) disable iff (!rst_b)
    (sfrWr && !bitWr && sfrAddr == `IEPR_ADDR_ENMAIN) |=> enMainOut == $past(sfrWdata))
    else $error("main enable write lost");

  chk_pri_bitwr: assert property (@(posedge clk) disable iff (!rst_b)
    (bitWr && !sfrWr && bitAddr == 8'hb8) |=> st.priMain[0] == $past(bitWval))
    else $error("priority bit write lost");

  chk_ext_write: assert property (@(posedge clk) disable iff (!rst_b)
    (sfrWr && sfrAddr == `IEPR_ADDR_ENEXT1) |=> enExt1Out == $past(sfrWdata))
    else $error("extended enable write lost");

  chk_pri_top_one: assert property (@(posedge clk) disable iff (!rst_b)
    (sfrRd && sfrAddr == `IEPR_ADDR_PRIMAIN) |=> sfrRdata[7])
    else $error("priority bit 7 read zero");

  chk_spi_masked: assert property (@(posedge clk) disable iff (!rst_b)
    !enMainOut[`IEPR_SPI_BIT] |-> !srcElig[6])
    else $error("masked spi request passed");

  chk_high_hold: assert property (@(posedge clk) disable iff (!rst_b)
    st.actHigh |-> !anyElig)
    else $error("high routine preempted");

  chk_low_preempt: assert property (@(posedge clk) disable iff (!rst_b)
    (!irqBusy && st.actLow && !st.actHigh && anyElig) |=> irqHigh)
    else $error("low level preempted a low routine");

  chk_fixed_order: assert property (@(posedge clk) disable iff (!rst_b)
    (!irqBusy && srcElig[0] && !anyHigh) |=> irqVector == 4'h0)
    else $error("fixed order not kept");

  chk_resp_five: assert property (@(posedge clk) disable iff (!rst_b)
    (!irqBusy && anyElig) |-> !irqEnter ##1 !irqEnter [*3] ##1 irqEnter)
    else $error("response not five cycles");

  chk_gate_no_call: assert property (@(posedge clk) disable iff (!rst_b)
    (!gateOn && !irqBusy) |=> !irqBusy)
    else $error("call started with global gate off");

  chk_level_pick: assert property (@(posedge clk) disable iff (!rst_b)
    (!irqBusy && !st.actHigh && |(srcReq & srcLevel)) |=> irqHigh)
    else $error("high level request lost to a low one");

  chk_pend_request: assert property (@(posedge clk) disable iff (!rst_b)
    (!irqBusy && !st.actHigh && !st.actLow && |srcReq) |=> irqBusy)
    else $error("unmasked pending flag not taken");

  chk_timer_two_gate: assert property (@(posedge clk) disable iff (!rst_b)
    (!irqBusy && !enMainOut[5]) |=> !(irqBusy && irqVector == 4'h5))
    else $error("masked timer 2 request passed");

  chk_uart_gate: assert property (@(posedge clk) disable iff (!rst_b)
    (!irqBusy && !enMainOut[4]) |=> !(irqBusy && irqVector == 4'h4))
    else $error("masked uart request passed");

  chk_timer_one_gate: assert property (@(posedge clk) disable iff (!rst_b)
    (!irqBusy && !enMainOut[3]) |=> !(irqBusy && irqVector == 4'h3))
    else $error("masked timer 1 request passed");

  chk_pin_one_gate: assert property (@(posedge clk) disable iff (!rst_b)
    (!irqBusy && !enMainOut[2]) |=> !(irqBusy && irqVector == 4'h2))
    else $error("masked external pin 1 request passed");

  chk_lin_gate: assert property (@(posedge clk) disable iff (!rst_b)
    (!irqBusy && !enExt1Out[7]) |=> !(irqBusy && irqVector == 4'he))
    else $error("masked lin request passed");

  chk_timer_three_gate: assert property (@(posedge clk) disable iff (!rst_b)
    (!irqBusy && !enExt1Out[6]) |=> !(irqBusy && irqVector == 4'hd))
    else $error("masked timer 3 request passed");

  chk_cmp_one_gate: assert property (@(posedge clk) disable iff (!rst_b)
    (!irqBusy && !enExt1Out[5]) |=> !(irqBusy && irqVector == 4'hc))
    else $error("masked comparator 1 request passed");

  chk_counter_gate: assert property (@(posedge clk) disable iff (!rst_b)
    (!irqBusy && !enExt1Out[3]) |=> !(irqBusy && irqVector == 4'ha))
    else $error("masked counter array request passed");

  chk_conv_gate: assert property (@(posedge clk) disable iff (!rst_b)
    (!irqBusy && !enExt1Out[2]) |=> !(irqBusy && irqVector == 4'h9))
    else $error("masked conversion request passed");

  chk_window_gate: assert property (@(posedge clk) disable iff (!rst_b)
    (!irqBusy && !enExt1Out[1]) |=> !(irqBusy && irqVector == 4'h8))
    else $error("masked window compare request passed");

  chk_smbus_gate: assert property (@(posedge clk) disable iff (!rst_b)
    (!irqBusy && !enExt1Out[0]) |=> !(irqBusy && irqVector == 4'h7))
    else $error("masked smbus request passed");

  cov_low_entry: cover property (@(posedge clk) disable iff (!rst_b)
    irqEnter && !irqHigh);
  cov_preempt: cover property (@(posedge clk) disable iff (!rst_b)
    irqEnter && irqHigh && st.actLow);
  cov_return: cover property (@(posedge clk) disable iff (!rst_b)
    svcReturn && st.actHigh && st.actLow);
  cov_high_direct: cover property (@(posedge clk) disable iff (!rst_b)
    irqEnter && irqHigh && !st.actLow);
  cov_gate_hold: cover property (@(posedge clk) disable iff (!rst_b)
    !gateOn && |srcPend);

endmodule

// ---- testbench/iepr_core_model.sv ----
// partner model: peripheral pending flags and the core's routine-return pulse
// assumes the bench sets and clears flags at the falling clock edge
`timescale 1ns/1ps
module iepr_core_model (
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic [18:0] setFlag,
  input  wire logic [18:0] clrFlag,
  input  wire logic        retReq,
  input  wire logic [1:0]  retDelay,
  output logic      [18:0] flags,
  output logic             svcReturn
);
  logic [2:0] retCnt;
  // flags are levels held until software clears them; return comes after a delay
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      flags     <= 19'h0;
      retCnt    <= 3'h0;
      svcReturn <= 1'b0;
    end else begin
      flags     <= (flags | setFlag) & ~clrFlag;
      svcReturn <= (retCnt == 3'h1);
      if (retReq) begin
        retCnt <= {1'b0, retDelay} + 3'h1;
      end else if (retCnt != 3'h0) begin
        retCnt <= retCnt - 3'h1;
      end
    end
  end
endmodule

// ---- testbench/testbench.sv ----
// self-checking bench for the interrupt enable and priority registers
// assumes iepr_pkg is compiled first and iepr_cfg.svh is on the include path
`timescale 1ns/1ps
module testbench;
  import iepr_pkg::*;
  logic        clk, rst_b, sfrWr, sfrRd, bitWr, bitRd, bitWval, retReq;
  logic [7:0]  sfrAddr, sfrWdata, sfrRdata, bitAddr, extLevel, enMainOut, enExt1Out;
  logic        bitRdata, irqBusy, irqEnter, irqHigh, svcReturn;
  logic [3:0]  irqVector;
  logic [18:0] setFlag, clrFlag, flags;
  logic [1:0]  retDelay;
  int          mismatches, comparisons;
  int          vtab[19] = '{0, 1, 2, 3, 4, 5, 5, 6, 7, 8, 9, 10, 11, 11, 12, 12, 13, 13, 14};
  // clock at 50 MHz
  always #10 clk = ~clk;
  iepr_core_model i_core (.clk(clk), .rst_b(rst_b), .setFlag(setFlag), .clrFlag(clrFlag),
    .retReq(retReq), .retDelay(retDelay), .flags(flags), .svcReturn(svcReturn));
  iepr_regs i_dut (.clk(clk), .rst_b(rst_b), .sfrAddr(sfrAddr), .sfrWr(sfrWr), .sfrRd(sfrRd),
    .sfrWdata(sfrWdata), .sfrRdata(sfrRdata), .bitAddr(bitAddr), .bitWr(bitWr),
    .bitRd(bitRd), .bitWval(bitWval), .bitRdata(bitRdata), .extPinZero(flags[0]),
    .timerZeroOverflow(flags[1]), .extPinOne(flags[2]), .timerOneOverflow(flags[3]),
    .asyncSerialPort(flags[4]), .timerTwoLowOverflow(flags[5]),
    .timerTwoHighOverflow(flags[6]), .serialPeriphPort(flags[7]), .smbusPort(flags[8]),
    .windowCompareFlag(flags[9]), .conversionDoneFlag(flags[10]), .counterArray(flags[11]),
    .comparatorZeroRise(flags[12]), .comparatorZeroFall(flags[13]),
    .comparatorOneRise(flags[14]), .comparatorOneFall(flags[15]),
    .timerThreeLowOverflow(flags[16]), .timerThreeHighOverflow(flags[17]),
    .linCtrlEvent(flags[18]), .extLevel(extLevel), .svcReturn(svcReturn), .irqBusy(irqBusy),
    .irqEnter(irqEnter), .irqVector(irqVector), .irqHigh(irqHigh), .enMainOut(enMainOut),
    .enExt1Out(enExt1Out));
  // verdict and end of run
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // byte and bit access, one strobe cycle each, read data the cycle after
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfrAddr = a; sfrWdata = d; sfrWr = 1'b1;
    @(negedge clk) sfrWr = 1'b0;
    @(negedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    sfrAddr = a; sfrRd = 1'b1;
    @(negedge clk) sfrRd = 1'b0;
    check("byte read", sfrRdata, exp);
    @(negedge clk);
  endtask
  task automatic bw(input logic [7:0] a, input logic v);
    bitAddr = a; bitWval = v; bitWr = 1'b1;
    @(negedge clk) bitWr = 1'b0;
    @(negedge clk);
  endtask
  task automatic br(input logic [7:0] a, input logic exp);
    bitAddr = a; bitRd = 1'b1;
    @(negedge clk) bitRd = 1'b0;
    check("bit read", {7'h0, bitRdata}, {7'h0, exp});
    @(negedge clk);
  endtask
  task automatic flag(input logic [18:0] s, input logic [18:0] c);
    setFlag = s; clrFlag = c;
    @(negedge clk) setFlag = 19'h0; clrFlag = 19'h0;
  endtask
  task automatic quiet(input int n);
    repeat (n) @(negedge clk) check("busy", {7'h0, irqBusy}, 8'h0);
  endtask
  // wait for detection, check winner, then entry three cycles after busy rises
  task automatic expect_irq(input logic [3:0] v, input logic h);
    int k;
    for (k = 0; k < 8 && irqBusy !== 1'b1; k++) @(negedge clk);
    if (irqBusy !== 1'b1) begin
      mismatches++;
      wrap_up();
    end
    check("vector", {4'h0, irqVector}, {4'h0, v});
    check("level", {7'h0, irqHigh}, {7'h0, h});
    repeat (3) @(negedge clk);
    check("entry", {7'h0, irqEnter}, 8'h1);
    @(negedge clk);
  endtask
  task automatic ret(input logic [1:0] d);
    retDelay = d; retReq = 1'b1;
    @(negedge clk) retReq = 1'b0;
    repeat (6) @(negedge clk);
  endtask
  initial begin
    {clk, rst_b, sfrWr, sfrRd, bitWr, bitRd, bitWval, retReq} = '0;
    {sfrAddr, sfrWdata, bitAddr, extLevel, setFlag, clrFlag, retDelay} = '0;
    repeat (12) @(negedge clk);
    rst_b = 1'b1;
    @(negedge clk);
    // reset values, unused priority bit, unmapped place
    rd(8'ha8, 8'h00);
    rd(8'hb8, 8'h80);
    rd(8'he6, 8'h00);
    rd(8'ha9, 8'h00);
    wr(8'hb8, 8'h7f);
    rd(8'hb8, 8'hff);
    bw(8'hbf, 1'b0);
    br(8'hbf, 1'b1);
    wr(8'hb8, 8'h00);
    rd(8'hb8, 8'h80);
    bw(8'hb8, 1'b1);
    rd(8'hb8, 8'h81);
    bw(8'hb8, 1'b0);
    bw(8'haf, 1'b1);
    check("enable main", enMainOut, 8'h80);
    br(8'haf, 1'b1);
    $display("test registers done");
    // global gate off blocks an unmasked source
    wr(8'ha8, 8'h02);
    flag(19'h2, 19'h0);
    quiet(5);
    bw(8'haf, 1'b1);
    expect_irq(4'h1, 1'b0);
    flag(19'h0, 19'h2);
    ret(2'h0);
    $display("test gate done");
    // every flag: masked is quiet, unmasked wins with its own vector
    for (int i = 0; i < 19; i++) begin
      wr(8'ha8, 8'h80);
      wr(8'he6, 8'h00);
      flag(19'h1 << i, 19'h0);
      quiet(4);
      if (vtab[i] < 7) wr(8'ha8, 8'h80 | (8'h1 << vtab[i]));
      else wr(8'he6, 8'h1 << (vtab[i] - 7));
      expect_irq(vtab[i][3:0], 1'b0);
      flag(19'h0, 19'h1 << i);
      ret(i[1:0]);
    end
    $display("test masks done");
    // equal levels use fixed order, a high extended source beats it
    wr(8'ha8, 8'h81);
    wr(8'he6, 8'h08);
    check("enable ext", enExt1Out, 8'h08);
    extLevel = 8'h08;
    flag(19'h801, 19'h0);
    expect_irq(4'ha, 1'b1);
    flag(19'h0, 19'h801);
    ret(2'h1);
    extLevel = 8'h00;
    flag(19'h801, 19'h0);
    expect_irq(4'h0, 1'b0);
    flag(19'h0, 19'h800);
    $display("test order done");
    // low routine active: high preempts, then a high routine holds off others
    wr(8'hb8, 8'h02);
    wr(8'ha8, 8'h83);
    flag(19'h2, 19'h0);
    expect_irq(4'h1, 1'b1);
    wr(8'hb8, 8'h06);
    wr(8'ha8, 8'h87);
    flag(19'h4, 19'h0);
    quiet(6);
    flag(19'h0, 19'h7);
    ret(2'h2);
    ret(2'h0);
    quiet(3);
    $display("test preemption done");
    wrap_up();
  end
endmodule
